/* File: src/uart_tx_params.svh */
// constants for the serial transmitter with rate divider
// assumes inclusion by bare name from every design file that needs it
`ifndef UART_TX_PARAMS_SVH
`define UART_TX_PARAMS_SVH

// system clock
`define CLK_PERIOD_NS 10

// transmit queue shape
`define TXQ_DEPTH 256
`define TXQ_WIDTH 8

// rate divider shape
`define DIV_WIDTH 16
`define DIV_SOURCES 8
`define DIV_SEL_W 3

// oversampling: last sub-bit count of a 16x bit
`define OVERSAMPLE 16
`define SUB_LAST 4'hf

// transmit clock select codes
`define CLKSEL_FIXED 2'h0
`define CLKSEL_DIVIDER 2'h1
`define CLKSEL_EXTERNAL 2'h2

// bid level codes of the two-bit field at mode_register_zero 5:4
`define BIDLVL_POS_HI 5
`define BIDLVL_POS_LO 4
`define BIDLVL_NOTFULL 2'h0
`define BIDLVL_EMPTY 2'h1
`define BIDLVL_LOW 2'h2
`define BIDLVL_HIGH 2'h3
`define BID_LOW_FILL 16
`define BID_HIGH_FILL 240

// character length: data bits are base plus the two-bit code
`define LEN_BASE 5

`endif

/* File: src/uart_tx_pkg.sv */
// types shared by the transmitter files
// assumes nothing beyond a SystemVerilog compiler
package uart_tx_pkg;

	// serializer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START,
		ST_DATA,
		ST_PARITY,
		ST_STOP
	} tx_state_type;

endpackage

/* File: src/tx_queue_fifo.sv */
// synchronous fifo with valid/ready on both sides and a flush
// assumes one clock and an active-low reset already synchronised
`timescale 1ns/1ps
module tx_queue_fifo #(
	parameter int WIDTH = 8, // word width
	parameter int DEPTH = 256, // words held
	parameter int CW = $clog2(DEPTH + 1) // count width
) (
	input wire logic clk, // system clock
	input wire logic rstn, // reset, active low
	input wire logic flush, // drop all content
	input wire logic inValid, // word offered
	output logic inReady, // space for a word
	input wire logic [WIDTH-1:0] inData, // word in
	output logic outValid, // word available
	input wire logic outReady, // word taken
	output logic [WIDTH-1:0] outData, // word out
	output logic [CW-1:0] count // words held
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_r;
	logic [AW-1:0] rdPtr_r;
	logic [CW-1:0] count_r;
	logic doWr;
	logic doRd;

	// full and empty come straight from the count
	assign inReady = (count_r != CW'(DEPTH)) && !flush;
	assign outValid = (count_r != '0) && !flush;
	assign outData = mem[rdPtr_r];
	assign count = count_r;
	assign doWr = inValid && inReady;
	assign doRd = outValid && outReady;

	// storage has no reset; only pointers and count need a defined value
	always_ff @(posedge clk) begin
		if (doWr) begin
			mem[wrPtr_r] <= inData;
		end
	end

	// pointers and count; flush empties at once
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else if (flush) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			if (doWr) begin
				wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
			end
			if (doRd) begin
				rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
			end
			if (doWr && !doRd) begin
				count_r <= count_r + 1'b1;
			end else if (doRd && !doWr) begin
				count_r <= count_r - 1'b1;
			end
		end
	end

endmodule

/* File: src/uart_tx_core.sv */
// transmit half of one serial channel with its rate divider and queue
// assumes all inputs synchronous to clk; commands are one-cycle pulses
`timescale 1ns/1ps
`include "uart_tx_params.svh"

// Overview of operation
// - divider counts the preset down for each half of a square wave
// - divider picks one of eight sources; run bit sits with the select
// - a divider output used as transmit clock is a 16x clock
// - space flag is high while enabled and the queue is not full
// - drained flag needs empty queue and last stop bit sent; implies space
// - enabling sets space and drained flags
// - a written character clears drained and restarts sending
// - reset, reset command or enable cleared disable; enable command restarts
// - writes are ignored while disabled; host enables before loading
// - reset stops at once, line high, flags clear, queue emptied
// - clearing enable lets queued characters and stop bits finish
// - enable bit low rejects characters and holds both flags low
// - break holds line low until stop-break or a reset
// - a break lasts at least one character time counted with one stop bit
// - data goes out at 1x; 1x logic clock only with external clock
// - queued character starts within one to two 16x ticks
// - queue holds 256 characters with programmable bid level
// - bid is empty slots less one; full queue makes no bid
// - two-bit level field at bits 5:4 delays bidding to a threshold
// - transmit clock is fixed generator, divider or external input
// - start, data lsb first, optional parity, stops; idle line high
module uart_tx_core #(
	parameter int DEPTH = `TXQ_DEPTH, // queue words
	parameter int WIDTH = `TXQ_WIDTH, // character width
	parameter int DIVW = `DIV_WIDTH, // divider preset width
	parameter int BIDW = $clog2(DEPTH) // bid value width
) (
	input wire logic clk, // system clock
	input wire logic resetn, // hardware reset, active low
	input wire logic cmdTxEnable, // enable command pulse
	input wire logic cmdTxDisable, // disable command pulse
	input wire logic cmdTxReset, // transmitter reset command pulse
	input wire logic cmdBreakStart, // start break command pulse
	input wire logic cmdBreakStop, // stop break command pulse
	input wire logic [1:0] dataLen, // data bits minus five
	input wire logic parityEn, // parity bit present
	input wire logic parityOdd, // odd parity when set
	input wire logic twoStop, // two stop bits when set
	input wire logic [7:0] modeZero, // mode_register_zero contents
	input wire logic [1:0] txClkSel, // transmit_clock_select code
	input wire logic extClk1x, // external clock used as 1x
	input wire logic fixedBaudClk, // fixed_baud_generator 16x output
	input wire logic extClk, // external clock input level
	input wire logic [`DIV_SOURCES-1:0] divSrc, // divider source levels
	input wire logic [`DIV_SEL_W-1:0] divSrcSel, // divider source select
	input wire logic divRun, // divider run, held with the select
	input wire logic [7:0] divPresetUpper, // divider_preset_upper
	input wire logic [7:0] divPresetLower, // divider_preset_lower
	input wire logic wrValid, // character offered to queue
	output logic wrReady, // character accepted
	input wire logic [WIDTH-1:0] wrData, // character
	output logic txd, // serial output
	output logic divOut, // divider square wave
	output logic txSpace, // transmit_space_flag
	output logic txDrained, // queue empty and stop bit sent
	output logic txEnabled, // enable bit state
	output logic txActive, // transmitter not yet disabled
	output logic bidValid, // queue bids for service
	output logic [BIDW-1:0] intBid // bid value
);
	localparam int CW = $clog2(DEPTH + 1);

	logic rstSync1_r, rstn, enable_r, breakOn_r, breakStopPend_r, bitTick, startNow;
	logic divOut_r, divSrcPrev_r, divSrcLvl, divEdge, clkLvl, clkPrev_r, clkEdge, mode1x;
	logic parity_r, stopIdx_r, txd_r, lineBit, qOutValid, qInReady, qFull, qEmpty;
	logic bidOk, bidValid_r;
	logic [1:0] bidLevel;
	logic [2:0] bitIdx_r, lastBit;
	logic [3:0] breakBits_r, sub_r, charBits;
	logic [DIVW-1:0] divCnt_r, divPreset;
	logic [WIDTH-1:0] shift_r, qOutData;
	logic [CW-1:0] qCount, freeLess1;
	logic [BIDW-1:0] intBid_r;
	uart_tx_pkg::tx_state_type state_r, state_nxt;

	// two-flop reset release; assertion stays asynchronous
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rstSync1_r <= 1'b0;
			rstn <= 1'b0;
		end else begin
			rstSync1_r <= 1'b1;
			rstn <= rstSync1_r;
		end
	end

	// enable bit: only an explicit enable command sets it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			enable_r <= 1'b0;
		end else if (cmdTxReset || cmdTxDisable) begin
			enable_r <= 1'b0;
		end else if (cmdTxEnable) begin
			enable_r <= 1'b1;
		end
	end

	// still active while queued work remains after enable clears
	assign txActive = enable_r || !qEmpty || (state_r != uart_tx_pkg::ST_IDLE);
	assign txEnabled = enable_r;

	// queue; writes only while enabled, reset command flushes
	tx_queue_fifo #(
		.WIDTH(WIDTH),
		.DEPTH(DEPTH),
		.CW(CW)
	) queue (
		.clk(clk),
		.rstn(rstn),
		.flush(cmdTxReset),
		.inValid(wrValid && enable_r),
		.inReady(qInReady),
		.inData(wrData),
		.outValid(qOutValid),
		.outReady(startNow),
		.outData(qOutData),
		.count(qCount)
	);

	assign wrReady = enable_r && qInReady;
	assign qFull = (qCount == CW'(DEPTH));
	assign qEmpty = (qCount == '0);

	// status flags are gated by the enable bit so disable clears both
	assign txSpace = enable_r && !qFull;
	assign txDrained = enable_r && qEmpty && (state_r == uart_tx_pkg::ST_IDLE);

	// divider source select and edge detect on the chosen level
	assign divSrcLvl = divSrc[divSrcSel];
	assign divEdge = divSrcLvl && !divSrcPrev_r;
	assign divPreset = {divPresetUpper, divPresetLower};
	assign divOut = divOut_r;

	// half-period countdown; a zero preset behaves as one
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			divSrcPrev_r <= 1'b0;
			divCnt_r <= '0;
			divOut_r <= 1'b0;
		end else begin
			divSrcPrev_r <= divSrcLvl;
			if (!divRun) begin
				divCnt_r <= divPreset;
			end else if (divEdge) begin
				if (divCnt_r <= DIVW'(1)) begin
					divCnt_r <= divPreset;
					divOut_r <= !divOut_r;
				end else begin
					divCnt_r <= divCnt_r - 1'b1;
				end
			end
		end
	end

	// transmit clock choice; only the external input may run as 1x
	always_comb begin
		clkLvl = fixedBaudClk;
		unique case (txClkSel)
			`CLKSEL_DIVIDER: clkLvl = divOut_r;
			`CLKSEL_EXTERNAL: clkLvl = extClk;
			default: clkLvl = fixedBaudClk;
		endcase
	end
	assign mode1x = (txClkSel == `CLKSEL_EXTERNAL) && extClk1x;
	assign clkEdge = clkLvl && !clkPrev_r;

	// sixteen ticks make one bit in 16x mode
	assign bitTick = clkEdge && (mode1x || (sub_r == `SUB_LAST));

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			clkPrev_r <= 1'b0;
			sub_r <= '0;
		end else begin
			clkPrev_r <= clkLvl;
			if (cmdTxReset || startNow || (cmdBreakStart && !breakOn_r)) begin
				sub_r <= '0; // a break counts whole bit times from its start
			end else if (clkEdge && !mode1x) begin
				sub_r <= sub_r + 1'b1;
			end
		end
	end

	// character shape
	assign lastBit = 3'(`LEN_BASE - 1) + {1'b0, dataLen};
	assign charBits = 4'(`LEN_BASE + 2) + {2'h0, dataLen} + {3'h0, parityEn};

	// a waiting character is taken on the next transmit clock edge
	assign startNow = (state_r == uart_tx_pkg::ST_IDLE) && qOutValid && !breakOn_r &&
		clkEdge && !cmdTxReset;

	// serializer next state
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			uart_tx_pkg::ST_IDLE: begin
				if (startNow) begin
					state_nxt = uart_tx_pkg::ST_START;
				end
			end
			uart_tx_pkg::ST_START: begin
				if (bitTick) begin
					state_nxt = uart_tx_pkg::ST_DATA;
				end
			end
			uart_tx_pkg::ST_DATA: begin
				if (bitTick && bitIdx_r == lastBit) begin
					state_nxt = parityEn ? uart_tx_pkg::ST_PARITY : uart_tx_pkg::ST_STOP;
				end
			end
			uart_tx_pkg::ST_PARITY: begin
				if (bitTick) begin
					state_nxt = uart_tx_pkg::ST_STOP;
				end
			end
			uart_tx_pkg::ST_STOP: begin
				if (bitTick && (stopIdx_r || !twoStop)) begin
					state_nxt = uart_tx_pkg::ST_IDLE;
				end
			end
			default: state_nxt = uart_tx_pkg::ST_IDLE;
		endcase
	end

	// state, shift register and bit counters
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= uart_tx_pkg::ST_IDLE;
			shift_r <= '0;
			bitIdx_r <= '0;
			parity_r <= 1'b0;
			stopIdx_r <= 1'b0;
		end else if (cmdTxReset) begin
			state_r <= uart_tx_pkg::ST_IDLE;
			bitIdx_r <= '0;
			stopIdx_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (startNow) begin
				shift_r <= qOutData;
				parity_r <= parityOdd;
				bitIdx_r <= '0;
				stopIdx_r <= 1'b0;
			end else if (bitTick && state_r == uart_tx_pkg::ST_DATA) begin
				shift_r <= {1'b0, shift_r[WIDTH-1:1]};
				parity_r <= parity_r ^ shift_r[0];
				bitIdx_r <= bitIdx_r + 1'b1;
			end else if (bitTick && state_r == uart_tx_pkg::ST_STOP) begin
				stopIdx_r <= 1'b1;
			end
		end
	end

	// level of the bit now being sent
	always_comb begin
		lineBit = 1'b1;
		unique case (state_r)
			uart_tx_pkg::ST_START: lineBit = 1'b0;
			uart_tx_pkg::ST_DATA: lineBit = shift_r[0];
			uart_tx_pkg::ST_PARITY: lineBit = parity_r;
			default: lineBit = 1'b1;
		endcase
	end

	// break: a stop request waits out one character of zeros, counted with one stop bit even when twoStop is set
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			breakOn_r <= 1'b0;
			breakStopPend_r <= 1'b0;
			breakBits_r <= '0;
		end else if (cmdTxReset) begin
			breakOn_r <= 1'b0;
			breakStopPend_r <= 1'b0;
			breakBits_r <= '0;
		end else if (cmdBreakStart && !breakOn_r) begin
			breakOn_r <= 1'b1;
			breakStopPend_r <= 1'b0;
			breakBits_r <= '0;
		end else if (breakOn_r) begin
			if (bitTick && breakBits_r != charBits) begin
				breakBits_r <= breakBits_r + 1'b1;
			end
			if (cmdBreakStop) begin
				breakStopPend_r <= 1'b1;
			end
			if ((cmdBreakStop || breakStopPend_r) && breakBits_r == charBits) begin
				breakOn_r <= 1'b0;
				breakStopPend_r <= 1'b0;
			end
		end
	end

	// line register: reset drives high at once, break wins over data
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			txd_r <= 1'b1;
		end else if (cmdTxReset) begin
			txd_r <= 1'b1;
		end else if (breakOn_r || cmdBreakStart) begin
			txd_r <= 1'b0;
		end else begin
			txd_r <= lineBit;
		end
	end
	assign txd = txd_r;

	// bid gating by the level field; code meanings are a local choice
	assign bidLevel = modeZero[`BIDLVL_POS_HI:`BIDLVL_POS_LO];
	always_comb begin
		bidOk = !qFull;
		unique case (bidLevel)
			`BIDLVL_EMPTY: bidOk = qEmpty;
			`BIDLVL_LOW: bidOk = qCount <= CW'(`BID_LOW_FILL);
			`BIDLVL_HIGH: bidOk = qCount <= CW'(`BID_HIGH_FILL);
			default: bidOk = !qFull;
		endcase
	end
	assign freeLess1 = CW'(DEPTH - 1) - qCount;

	// registered bid; value is empty positions less one
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bidValid_r <= 1'b0;
			intBid_r <= '0;
		end else begin
			bidValid_r <= bidOk && !qFull;
			intBid_r <= qFull ? '0 : freeLess1[BIDW-1:0];
		end
	end
	assign bidValid = bidValid_r;
	assign intBid = intBid_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	drained_space_a: assert property (txDrained |-> txSpace)
		else $error("drained flag without space flag");
	write_undrain_a: assert property ((wrValid && wrReady) |=> !txDrained)
		else $error("drained flag stayed after a write");
	reset_stop_a: assert property (cmdTxReset |=> txd && !txSpace && qCount == '0)
		else $error("reset did not stop transmitter");
	disabled_reject_a: assert property (!enable_r |-> !wrReady && !txSpace && !txDrained)
		else $error("disabled transmitter accepted or flagged");
	break_low_a: assert property (breakOn_r |=> !txd || $past(cmdTxReset))
		else $error("line rose during break");
	start_latency_a: assert property (startNow |=> state_r == uart_tx_pkg::ST_START ##1
		(!txd || $past(cmdTxReset)))
		else $error("queued character did not start");
	sub_hold_a: assert property ((clkEdge && !mode1x && sub_r != `SUB_LAST &&
		state_r != uart_tx_pkg::ST_IDLE && !cmdTxReset) |=> state_r == $past(state_r))
		else $error("bit ended before sixteen ticks");
	div_toggle_a: assert property ((divRun && divEdge && divCnt_r <= DIVW'(1)) |=>
		divOut_r != $past(divOut_r))
		else $error("divider did not toggle at terminal count");
	empty_bid_a: assert property ((qEmpty && bidLevel == `BIDLVL_NOTFULL) |=>
		bidValid && intBid == '1)
		else $error("empty queue bid wrong");
	idle_high_a: assert property ((state_r == uart_tx_pkg::ST_IDLE && !breakOn_r &&
		!cmdBreakStart) |=> txd)
		else $error("idle line not high");
	drain_active_a: assert property ((!enable_r && qOutValid && clkEdge && !breakOn_r &&
		state_r == uart_tx_pkg::ST_IDLE && !cmdTxReset) |=> state_r == uart_tx_pkg::ST_START)
		else $error("queued character not sent after disable");

endmodule

/* File: bench/uart_rx_model.sv */
// behavioural far-end receiver that samples the serial line at bit centres
// assumes a fixed bit length in system clocks and a line that idles high
`timescale 1ns/1ps
module uart_rx_model #(
	parameter int BITCYC = 32 // system clocks per bit
) (
	input wire logic clk, // system clock
	input wire logic txd, // serial line from the transmitter
	input wire logic [1:0] dataLen, // data bits minus five
	input wire logic parityEn, // parity bit expected
	input wire logic parityOdd, // odd parity when set
	input wire logic twoStop, // two stop bits when set
	output logic [7:0] rxByte, // last character taken
	output int rxCount, // frames seen
	output int rxErr // bad start, parity and stop bits seen, one count per bad bit
);
	logic [7:0] d;
	// one frame at a time; a break also ends as a counted, faulty frame
	initial begin
		rxByte = 8'h00;
		rxCount = 0;
		rxErr = 0;
		forever begin
			@(negedge txd);
			repeat (BITCYC / 2) @(posedge clk);
			if (txd !== 1'b0) rxErr++;
			d = 8'h00;
			for (int i = 0; i < 5 + dataLen; i++) begin
				repeat (BITCYC) @(posedge clk);
				d[i] = txd;
			end
			if (parityEn) begin
				repeat (BITCYC) @(posedge clk);
				if (txd !== (^d ^ parityOdd)) rxErr++;
			end
			repeat (BITCYC) @(posedge clk);
			if (txd !== 1'b1) rxErr++;
			if (twoStop) begin
				repeat (BITCYC) @(posedge clk);
				if (txd !== 1'b1) rxErr++;
			end
			rxByte = d;
			rxCount++;
		end
	end
endmodule

/* File: bench/uart_transmitter_with_rate_divider_tb.sv */
// self-checking bench for the serial transmitter and its rate divider
// assumes the fixed generator at half the system rate, save one external 1x test
`timescale 1ns/1ps
module uart_transmitter_with_rate_divider_tb;
	logic clk, resetn, wrValid, parityEn, parityOdd, twoStop, fixedBaudClk, baudRun, divRun;
	logic txd, divOut, txSpace, txDrained, txEnabled, txActive, bidValid, wrReady, keep;
	logic [4:0] cmdV, extCnt;
	logic extClk1x;
	logic [4:0] fmt [3];
	logic [1:0] dataLen, txClkSel;
	logic [7:0] wrData, modeZero, divSrc, divPresetLower, intBid, rxByte;
	int rxCount, rxErr, fails, check_count, n, k;

	uart_tx_core dut (.clk(clk), .resetn(resetn), .cmdTxEnable(cmdV[0]),
		.cmdTxDisable(cmdV[1]), .cmdTxReset(cmdV[2]), .cmdBreakStart(cmdV[3]),
		.cmdBreakStop(cmdV[4]), .dataLen(dataLen), .parityEn(parityEn),
		.parityOdd(parityOdd), .twoStop(twoStop), .modeZero(modeZero),
		.txClkSel(txClkSel), .extClk1x(extClk1x), .fixedBaudClk(fixedBaudClk),
		.extClk(extCnt[4]),
		.divSrc(divSrc), .divSrcSel(3'h5), .divRun(divRun), .divPresetUpper(8'h00),
		.divPresetLower(divPresetLower), .wrValid(wrValid), .wrReady(wrReady),
		.wrData(wrData), .txd(txd), .divOut(divOut), .txSpace(txSpace),
		.txDrained(txDrained), .txEnabled(txEnabled), .txActive(txActive),
		.bidValid(bidValid), .intBid(intBid));

	uart_rx_model #(.BITCYC(32)) model (.clk(clk), .txd(txd), .dataLen(dataLen),
		.parityEn(parityEn), .parityOdd(parityOdd), .twoStop(twoStop),
		.rxByte(rxByte), .rxCount(rxCount), .rxErr(rxErr));

	// system clock, 10 ns period
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// 16x transmit clock at half rate; stopping it freezes the serializer
	// extCnt[4] rises once per 32 clocks: a 1x clock with the model's bit length
	always @(posedge clk) begin
		if (baudRun) fixedBaudClk <= ~fixedBaudClk;
		divSrc <= ~divSrc;
		extCnt <= extCnt + 5'h01;
	end

	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic pick(input int sel);
		case (sel)
			0: return txd;
			1: return txDrained;
			2: return txActive;
			default: return divOut;
		endcase
	endfunction

	// bounded wait on a settled output; n ends as the cycles spent
	task await(input int sel, input logic lvl, input int lim);
		@(negedge clk);
		for (n = 0; n < lim && pick(sel) !== lvl; n++) @(negedge clk);
		if (pick(sel) !== lvl) begin
			check(16'h0, 16'h1);
			give_verdict;
		end
	endtask

	// one-cycle command pulse: 0 enable, 1 disable, 2 reset, 3 break, 4 stop break
	task cmd(input int k);
		@(posedge clk);
		cmdV <= 5'(1 << k);
		@(posedge clk);
		cmdV <= 5'h00;
	endtask

	// offer a character; ready is looked at settled, the taking edge follows
	task put(input logic [7:0] d, input logic acc);
		logic got;
		got = 1'b0;
		@(posedge clk);
		wrValid <= 1'b1;
		wrData <= d;
		for (int i = 0; i < 8 && !got; i++) begin
			@(negedge clk);
			got = (wrReady === 1'b1);
		end
		@(posedge clk);
		wrValid <= 1'b0;
		check(16'(got), 16'(acc));
	endtask

	// wait for the far end to finish a frame and compare its character
	task rx(input logic [7:0] e);
		int c;
		c = rxCount;
		for (int i = 0; i < 2000 && rxCount == c; i++) @(negedge clk);
		check(16'(rxCount), 16'(c + 1));
		check(16'(rxByte), 16'(e));
	endtask

	// main sequence
	initial begin
		resetn = 1'b0;
		cmdV = 5'h00;
		wrValid = 1'b0;
		wrData = 8'h00;
		{dataLen, parityEn, parityOdd, twoStop} = 5'b11000;
		fmt = '{5'b00101, 5'b01110, 5'b10001};
		modeZero = 8'h00;
		fixedBaudClk = 1'b0;
		divSrc = 8'h00;
		extCnt = 5'h00;
		txClkSel = 2'h0;
		extClk1x = 1'b0;
		baudRun = 1'b1;
		divRun = 1'b0;
		divPresetLower = 8'h03;
		fails = 0;
		check_count = 0;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		@(negedge clk);
		check(16'(txd), 16'h1);
		check(16'({txSpace, txDrained, wrReady}), 16'h0);
		put(8'h11, 1'b0);
		cmd(0);
		repeat (2) @(negedge clk);
		check(16'({txEnabled, txSpace, txDrained}), 16'h7);
		check(16'({bidValid, intBid}), 16'h1ff);
		// plain character, its start delay and the drained flag around it
		put(8'ha5, 1'b1);
		@(negedge clk);
		check(16'(txDrained), 16'h0);
		await(0, 1'b0, 40);
		check(16'(n < 8), 16'h1);
		rx(8'ha5);
		await(1, 1'b1, 100);
		// lengths, parity kinds and stop counts from a table
		for (k = 0; k < 3; k++) begin
			@(posedge clk);
			{dataLen, parityEn, parityOdd, twoStop} <= fmt[k];
			put(8'hd6, 1'b1);
			rx(8'hd6 & 8'((16'h1 << (5 + fmt[k][4:3])) - 1));
		end
		@(posedge clk);
		{dataLen, parityEn, parityOdd, twoStop} <= 5'b11000;
		// disable with two queued: flags drop now, sending goes on
		put(8'h3c, 1'b1);
		put(8'hc3, 1'b1);
		cmd(1);
		@(negedge clk);
		check(16'({txSpace, txDrained, wrReady, txActive}), 16'h1);
		put(8'h77, 1'b0);
		rx(8'h3c);
		rx(8'hc3);
		await(2, 1'b0, 200);
		// external clock taken as 1x: one edge per bit
		@(posedge clk);
		txClkSel <= 2'h2;
		extClk1x <= 1'b1;
		cmd(0);
		put(8'h96, 1'b1);
		rx(8'h96);
		await(1, 1'b1, 100);
		@(posedge clk);
		txClkSel <= 2'h0;
		extClk1x <= 1'b0;
		cmd(1);
		check(16'(rxErr), 16'h0);
		// frozen serializer: fill to refusal, watch the bid, then discard
		baudRun <= 1'b0;
		cmd(0);
		modeZero <= 8'h10;
		put(8'h01, 1'b1);
		repeat (2) @(negedge clk);
		check(16'(bidValid), 16'h0);
		modeZero <= 8'h00;
		for (k = 0; k < 254; k++) put(8'(k), 1'b1);
		repeat (2) @(negedge clk);
		check(16'({txSpace, bidValid, intBid}), 16'h300);
		put(8'hee, 1'b1);
		repeat (2) @(negedge clk);
		check(16'({txSpace, bidValid, intBid}), 16'h0);
		put(8'hef, 1'b0);
		cmd(2);
		@(negedge clk);
		check(16'({txEnabled, txSpace, txDrained}), 16'h0);
		cmd(0);
		repeat (2) @(negedge clk);
		check(16'({txDrained, intBid}), 16'h1ff);
		baudRun <= 1'b1;
		// break held past an early stop request, queue held meanwhile
		cmd(3);
		@(negedge clk);
		check(16'(txd), 16'h0);
		put(8'hff, 1'b1);
		cmd(4);
		repeat (250) @(negedge clk);
		check(16'(txd), 16'h0);
		await(0, 1'b1, 200);
		rx(8'hff);
		cmd(3);
		repeat (5) @(posedge clk);
		cmd(2);
		@(negedge clk);
		check(16'(txd), 16'h1);
		// reset in mid-character stops at once and leaves it disabled
		cmd(0);
		put(8'h00, 1'b1);
		await(0, 1'b0, 40);
		repeat (50) @(negedge clk);
		cmd(2);
		@(negedge clk);
		check(16'({txd, txActive}), 16'h2);
		repeat (40) @(negedge clk);
		check(16'(txd), 16'h1);
		put(8'h55, 1'b0);
		// divider halves of three source edges, two clocks apart each
		@(posedge clk);
		divRun <= 1'b1;
		await(3, 1'b1, 100);
		await(3, 1'b0, 100);
		check(16'(n + 1), 16'h6);
		await(3, 1'b1, 100);
		check(16'(n + 1), 16'h6);
		@(posedge clk);
		divRun <= 1'b0;
		repeat (2) @(negedge clk);
		keep = divOut;
		repeat (20) @(negedge clk);
		check(16'(divOut), 16'(keep));
		give_verdict;
	end
endmodule
